// ===== test/asu_remote_model.sv
// remote serial device model facing the transmit and receive lines
`timescale 1ns/1ps

module asu_remote_model (
	// clock
	input  wire logic sys_clk_in,
	// serial lines
	input  wire logic txd_in,
	output logic      rxd_out
);
	// line rests high as with a pull-up between frames
	initial rxd_out = 1'b1;

	// hold one level for cyc clock periods
	task automatic drive_bit(input logic v, input int cyc);
		@(posedge sys_clk_in);
		rxd_out <= v;
		repeat (cyc - 1) @(posedge sys_clk_in);
	endtask

	// bad_stop names a stop bit to pull low, 0 for none
	task automatic send_frame(input logic [7:0] d, input logic pe,
			input logic par, input int ns, input int bad_stop,
			input int cyc);
		drive_bit(1'b0, cyc);
		for (int i = 0; i < 8; i++) drive_bit(d[i], cyc);
		if (pe) drive_bit(par, cyc);
		for (int i = 1; i <= ns; i++) drive_bit(i != bad_stop, cyc);
		drive_bit(1'b1, 1);
	endtask

	// short low pulse, meant to be swallowed by the filter
	task automatic glitch(input int n);
		drive_bit(1'b0, n);
		drive_bit(1'b1, 1);
	endtask

	// sample each bit in its middle; t marks the falling start edge
	task automatic get_frame(input logic pe, input int ns, input int cyc,
			output logic [7:0] d, output logic par, output logic ok,
			output time t);
		@(negedge txd_in);
		t = $time;
		repeat (cyc / 2) @(posedge sys_clk_in);
		ok = (txd_in === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (cyc) @(posedge sys_clk_in);
			d[i] = txd_in;
		end
		par = 1'b0;
		if (pe) begin
			repeat (cyc) @(posedge sys_clk_in);
			par = txd_in;
		end
		for (int i = 0; i < ns; i++) begin
			repeat (cyc) @(posedge sys_clk_in);
			ok = ok & (txd_in === 1'b1);
		end
	endtask
endmodule

// ===== test/async_serial_uart_tb_top.sv
// self-checking bench for the serial port and its remote partner
`timescale 1ns/1ps
`include "asu_regs.svh"

module async_serial_uart_tb_top;
	localparam logic [7:0] ST = `ASU_OFF_CTL1_STAT;
	localparam logic [7:0] C2 = `ASU_OFF_CTL2;
	localparam logic [7:0] DB = `ASU_OFF_DATA;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       tmr = 1'b0;
	logic [1:0] tcnt = 2'h0;
	logic [7:0] rdata;
	logic       txd;
	logic       rxd;
	logic       tx_irq;
	logic       rx_irq;
	int         mismatches = 0;
	int         cmp_count = 0;
	int         tx_n = 0;
	int         rx_n = 0;
	// format table: plain at fc/26, odd+2 stops, even, even+2 stops
	logic [7:0] fmt [4] = '{8'h81, 8'hA8, 8'h98, 8'hB8};
	// receive cases: parity, even, two stops, bad parity, bad stop
	logic [5:0] pe_t = 6'b100110;
	logic [5:0] ev_t = 6'b000010;
	logic [5:0] s2_t = 6'b110000;
	logic [5:0] bp_t = 6'b000100;
	int         bs_t [6] = '{0, 0, 0, 1, 2, 0};
	logic [7:0] es_t [6] = '{8'h1C, 8'h1C, 8'h9C, 8'h5C, 8'h5C, 8'h1C};

	asu_uart asu_uart_i (
		.sys_clk_in(clk), .sys_rst_in(rst), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.timer_three_match_event_in(tmr), .txd_out(txd), .rxd_in(rxd),
		.transmit_interrupt_out(tx_irq), .receive_interrupt_out(rx_irq));
	asu_remote_model asu_remote_model_i (
		.sys_clk_in(clk), .txd_in(txd), .rxd_out(rxd));

	// 50 ns period
	initial begin
		forever #25 clk = ~clk;
	end

	// count event pulses; a timer match every third cycle
	always @(posedge clk) begin
		if (tx_irq === 1'b1) tx_n++;
		if (rx_irq === 1'b1) rx_n++;
		tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
		tmr <= (tcnt == 2'h2);
	end

	task automatic complete_run();
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t value %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_num(input int g, input int e, input int tol);
		cmp_count++;
		if (g < e - tol || g > e + tol) begin
			mismatches++;
			$display("[ERR] %0t count %0d expected %0d", $time, g, e);
		end
	endtask

	// one-cycle strobes, changed right after the edge
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// parity bit: odd when ev is 0, even when 1
	function automatic logic pbit(input logic [7:0] d, input logic ev);
		return (^d) ^ ~ev;
	endfunction

	task automatic wait_rx(input int want);
		int k;
		k = 0;
		while (rx_n < want && k < 400) begin
			@(posedge clk);
			k++;
		end
		chk_num(rx_n, want, 0);
	endtask

	// two frames back to back; their start spacing gives the frame length
	task automatic tx_pair(input logic [7:0] ctl, input int cyc);
		logic [7:0] a, b, ga, gb, s;
		logic pa, pb, oa, ob;
		time ta, tb;
		int n0, len;
		a = 8'($urandom);
		b = 8'($urandom);
		n0 = tx_n;
		len = 10 + ctl[3] + ctl[5];
		reg_wr(ST, 8'h00);
		reg_wr(ST, ctl);
		fork
			begin
				asu_remote_model_i.get_frame(ctl[3], 1 + ctl[5], cyc, ga,
					pa, oa, ta);
				asu_remote_model_i.get_frame(ctl[3], 1 + ctl[5], cyc, gb,
					pb, ob, tb);
			end
			begin
				reg_rd(ST, s);
				reg_wr(DB, a);
				repeat (4) @(posedge clk);
				reg_rd(ST, s);
				reg_wr(DB, b);
			end
		join
		repeat (cyc) @(posedge clk);
		chk_val(ga, a);
		chk_val(gb, b);
		chk_val({6'h0, oa, ob}, 8'h03);
		if (ctl[3])
			chk_val({pa, pb}, {pbit(a, ctl[4]), pbit(b, ctl[4])});
		chk_num(int'((tb - ta) / 50), len * cyc, cyc / 16 + 4);
		chk_num(tx_n, n0 + 2, 0);
		reg_rd(ST, s);
		chk_val(s, 8'h0C);
	endtask

	task automatic rx_one(input logic [7:0] d, input logic pe,
			input logic ev, input int ns, input int bst, input logic bp,
			input logic [7:0] e);
		logic [7:0] s;
		int want;
		want = rx_n + 1;
		asu_remote_model_i.send_frame(d, pe, pbit(d, ev) ^ bp, ns, bst, 208);
		wait_rx(want);
		reg_rd(ST, s);
		chk_val(s, e);
		reg_rd(DB, s);
		chk_val(s, d);
		reg_rd(ST, s);
		chk_val(s, 8'h0C);
	endtask

	// main sequence
	initial begin
		logic [7:0] s, d, g;
		logic p, o;
		time t;
		int n0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		n0 = $urandom(45);
		reg_rd(ST, s);
		chk_val(s, 8'h0C);
		reg_rd(C2, s);
		chk_val(s, 8'h00);
		reg_rd(DB, s);
		chk_val(s, 8'h00);
		reg_rd(8'h40, s);
		chk_val(s, 8'h00);
		chk_val({7'h0, txd}, 8'h01);
		foreach (fmt[i]) tx_pair(fmt[i], 208 << fmt[i][0]);
		tx_pair(8'h8F, 1536);
		tx_pair(8'hA6, 48);
		reg_wr(ST, 8'h00);
		for (int i = 0; i < 6; i++) begin
			reg_wr(ST, {3'b010, ev_t[i], pe_t[i], 3'h0});
			reg_wr(C2, {7'h0, s2_t[i]});
			rx_one(8'($urandom), pe_t[i], ev_t[i], 1 + s2_t[i], bs_t[i],
				bp_t[i], es_t[i]);
		end
		// a 20-cycle pulse dies in the filter, a full frame passes
		reg_wr(ST, 8'h40);
		reg_wr(C2, 8'h02);
		n0 = rx_n;
		asu_remote_model_i.glitch(20);
		repeat (600) @(posedge clk);
		chk_num(rx_n, n0, 0);
		rx_one(8'hA5, 1'b0, 1'b0, 1, 0, 1'b0, 8'h1C);
		// second byte lands on a full buffer
		reg_wr(C2, 8'h00);
		asu_remote_model_i.send_frame(8'h3C, 1'b0, 1'b0, 1, 0, 208);
		asu_remote_model_i.send_frame(8'hC3, 1'b0, 1'b0, 1, 0, 208);
		repeat (100) @(posedge clk);
		reg_rd(ST, s);
		chk_val(s, 8'h3C);
		reg_rd(DB, s);
		chk_val(s, 8'h3C);
		rx_one(8'h69, 1'b0, 1'b0, 1, 0, 1'b0, 8'h1C);
		// disable mid-frame, then stale and unarmed writes must not send
		reg_wr(ST, 8'h00);
		reg_wr(ST, 8'h80);
		d = 8'($urandom);
		fork
			asu_remote_model_i.get_frame(1'b0, 1, 208, g, p, o, t);
			begin
				reg_rd(ST, s);
				reg_wr(DB, d);
				repeat (600) @(posedge clk);
				reg_wr(ST, 8'h00);
			end
		join
		chk_val(g, d);
		repeat (208) @(posedge clk);
		reg_rd(ST, s);
		reg_wr(DB, ~d);
		reg_wr(ST, 8'h80);
		reg_wr(DB, 8'h5A);
		n0 = 0;
		repeat (2600) begin
			@(posedge clk);
			if (txd !== 1'b1) n0++;
		end
		chk_num(n0, 0, 0);
		fork
			asu_remote_model_i.get_frame(1'b0, 1, 208, g, p, o, t);
			begin
				reg_rd(ST, s);
				reg_wr(DB, 8'hE1);
			end
		join
		chk_val(g, 8'hE1);
		complete_run();
	end

	// watchdog, about one and a third times the planned run
	initial begin
		#6000000;
		mismatches++;
		$display("[ERR] %0t timeout", $time);
		complete_run();
	end
endmodule

// ===== verilog/asu_noise_filter.sv
// receive line synchroniser and selectable noise rejection filter
`timescale 1ns/1ps
`include "asu_regs.svh"

module asu_noise_filter
	import asu_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       sys_rst_in,
	// line and setting
	input  wire logic       line_in,
	input  wire logic [1:0] mode_in,
	// cleaned level
	output logic            line_out
);

	logic       sync1_r;
	logic       sync2_r;
	logic       line_r;
	logic [7:0] run_r;
	logic [7:0] need;

	// two flops before anything looks at the pin; idle line is high
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= line_in;
			sync2_r <= sync1_r;
		end
	end

	// hold time a new level needs before it is believed
	always_comb begin
		case (mode_in)
			2'b01:   need = {1'b0, `ASU_NF_LEN_1};
			2'b10:   need = {1'b0, `ASU_NF_LEN_2};
			default: need = `ASU_NF_LEN_3;
		endcase
	end

	// with filtering on a change must persist; shorter pulses never reach the receiver
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			line_r <= 1'b1;
			run_r  <= 8'h00;
		end else if (mode_in == 2'b00) begin
			line_r <= sync2_r;
			run_r  <= 8'h00;
		end else if (sync2_r == line_r) begin
			run_r <= 8'h00;
		end else if (run_r == need - 8'h01) begin
			line_r <= sync2_r; // R9 R10
			run_r  <= 8'h00;
		end else begin
			run_r <= run_r + 8'h01;
		end
	end

	assign line_out = line_r;

	// a flip with filtering on needs the full hold count behind it
	a_filter_hold: assert property (@(posedge sys_clk_in) // R9
		disable iff (sys_rst_in)
		(mode_in != 2'b00 && $stable(mode_in) && line_r != sync2_r
		&& run_r != need - 8'h01) |=> $stable(line_r))
		else $error("filter passed a short pulse");

endmodule

// ===== verilog/asu_pkg.sv
// types shared by the serial port design files
package asu_pkg;

	typedef enum logic [2:0] {
		ASU_TX_IDLE   = 3'b000,
		ASU_TX_START  = 3'b001,
		ASU_TX_DATA   = 3'b010,
		ASU_TX_PARITY = 3'b011,
		ASU_TX_STOP   = 3'b100
	} asu_tx_state_t;

	typedef enum logic [2:0] {
		ASU_RX_IDLE   = 3'b000,
		ASU_RX_START  = 3'b001,
		ASU_RX_DATA   = 3'b010,
		ASU_RX_PARITY = 3'b011,
		ASU_RX_STOP   = 3'b100
	} asu_rx_state_t;

endpackage

// ===== verilog/asu_regs.svh
// register offsets, field positions, reset values and counts of the serial port
`ifndef ASU_REGS_SVH
`define ASU_REGS_SVH

// register offsets (byte addresses on the plain register port)
`define ASU_OFF_CTL1_STAT   8'h25
`define ASU_OFF_CTL2        8'h26
`define ASU_OFF_DATA        8'h27

// control one fields
`define ASU_C1_TXE          7
`define ASU_C1_RXE          6
`define ASU_C1_TRANSMIT_STOP_LENGTH         5
`define ASU_C1_EVEN         4
`define ASU_C1_PE           3
`define ASU_C1_RATE_HI      2
`define ASU_C1_RATE_LO      0
`define ASU_C1_RESET        8'h00

// control two fields
`define ASU_C2_NF_HI        2
`define ASU_C2_NF_LO        1
`define ASU_C2_RECEIVE_STOP_LENGTH       0
`define ASU_C2_RESET        3'h0

// status fields
`define ASU_ST_PARITY_ERROR_FLAG         7
`define ASU_ST_FRAMING_ERROR_FLAG         6
`define ASU_ST_OVERRUN_FLAG         5
`define ASU_ST_RECEIVE_FULL_FLAG         4
`define ASU_ST_TRANSMIT_DONE_FLAG         3
`define ASU_ST_TRANSMIT_EMPTY_FLAG         2
`define ASU_BUF_RESET       8'h00

// rate select codes and dividers of fc
`define ASU_RATE_TIMER      3'h6
`define ASU_DIV_0           9'h00D
`define ASU_DIV_1           9'h01A
`define ASU_DIV_2           9'h034
`define ASU_DIV_3           9'h068
`define ASU_DIV_4           9'h0D0
`define ASU_DIV_5           9'h1A0
`define ASU_DIV_7           9'h060

// sub-bit ticks per bit and the three sample ticks
`define ASU_TICK_LAST       4'hF
`define ASU_SAMPLE_A        4'h7
`define ASU_SAMPLE_B        4'h8
`define ASU_SAMPLE_C        4'h9
`define ASU_DATA_LAST       3'h7

// noise filter: a level must hold this many fc periods to pass
`define ASU_NF_LEN_1        7'h20
`define ASU_NF_LEN_2        7'h40
`define ASU_NF_LEN_3        8'h80

`endif

// ===== verilog/asu_uart.sv
// asynchronous serial transmitter and receiver with register port
`timescale 1ns/1ps
`include "asu_regs.svh"

// Notes on behaviour
// R1: frame is start low, data, parity, stops
// R2: transmit stop length selects one or two
// R3: receive stop length separate, one or two
// R4: parity enable adds bit; type odd/even
// R5: rate select picks divider or timer event
// R6: timer event is the sixteen-tick clock
// R7: idle receiver samples for low start
// R8: samples at ticks 7,8,9, majority vote
// R9: filter rejects short pulses per setting
// R10: filter passes long pulses per setting
// R11: disable waits for current frame end
// R12: stale buffer not sent on re-enable
// R13: one rate and parity for both
// R14: software disables both before rate change
// R15: transmit interrupt sets buffer empty flag
// R16: status read-only, bits 7..2, reset values
// R17: shared addresses for control/status and buffers
// R18: control registers write-only, reset zero
// R19: software changes format only by sequence
// R20: status read then write starts; idle high
// R21: buffer read after status clears rx flags
// R22: overrun discards byte, blocks reception
// R23: framing and parity error detection
// R24: eight data bits, lsb first
// R25: sixteen sub-bit ticks per bit
module asu_uart
	import asu_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       sys_rst_in,
	// register port
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	// rate source from the timer, same clock
	input  wire logic       timer_three_match_event_in,
	// serial lines
	output logic            txd_out,
	input  wire logic       rxd_in,
	// event pulses
	output logic            transmit_interrupt_out,
	output logic            receive_interrupt_out
);

	// odd parity when even is clear: bit makes the ones count odd
	function automatic logic parity_of(input logic [7:0] d,
		input logic even);
		parity_of = (^d) ^ ~even; // R4
	endfunction

	function automatic logic majority(input logic [2:0] s);
		majority = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]); // R8
	endfunction

	function automatic logic [8:0] divider_of(input logic [2:0] code);
		case (code)
			3'h0:    divider_of = `ASU_DIV_0;
			3'h1:    divider_of = `ASU_DIV_1;
			3'h2:    divider_of = `ASU_DIV_2;
			3'h3:    divider_of = `ASU_DIV_3;
			3'h4:    divider_of = `ASU_DIV_4;
			3'h5:    divider_of = `ASU_DIV_5;
			default: divider_of = `ASU_DIV_7;
		endcase
	endfunction

	logic [7:0]    ctl1_r;
	logic [2:0]    ctl2_r;
	logic [7:0]    rdata_r;
	logic          tx_armed_r;
	logic          rx_armed_r;
	logic [8:0]    div_cnt_r;
	logic          tick_r;
	logic [7:0]    tbuf_r;
	logic          pending_r;
	logic          transmit_empty_flag_r;
	logic          transmit_done_flag_r;
	asu_tx_state_t tx_state_r;
	logic [3:0]    tx_sub_r;
	logic [2:0]    tx_idx_r;
	logic          tx_stop_r;
	logic [7:0]    tx_shift_r;
	logic          txd_r;
	logic          tx_int_r;
	logic          tx_end_r;
	asu_rx_state_t rx_state_r;
	logic [3:0]    rx_sub_r;
	logic [2:0]    rx_idx_r;
	logic          rx_stop_r;
	logic [2:0]    rx_samp_r;
	logic [7:0]    rx_shift_r;
	logic          rx_par_r;
	logic          rx_framing_error_flag_r;
	logic          rx_done_r;
	logic          rx_parity_error_flag_hit_r;
	logic          rx_framing_error_flag_hit_r;
	logic [7:0]    rbuf_r;
	logic          parity_error_flag_r;
	logic          framing_error_flag_r;
	logic          overrun_flag_r;
	logic          receive_full_flag_r;
	logic          rx_int_r;
	logic          rxd_clean;
	logic          wr_ctl1;
	logic          rd_stat;
	logic          wr_tbuf;
	logic          rd_rbuf;
	logic          tx_load;
	logic          rx_clear;
	logic          rx_bit;
	logic          rx_framing_error_flag_now;

	assign wr_ctl1  = wr_in && addr_in == `ASU_OFF_CTL1_STAT;
	assign rd_stat  = rd_in && addr_in == `ASU_OFF_CTL1_STAT;
	assign wr_tbuf  = wr_in && addr_in == `ASU_OFF_DATA;
	assign rd_rbuf  = rd_in && addr_in == `ASU_OFF_DATA;
	assign tx_load  = tx_state_r == ASU_TX_IDLE && pending_r
		&& ctl1_r[`ASU_C1_TXE];
	assign rx_clear = rd_rbuf && rx_armed_r; // R21
	assign rx_bit   = majority(rx_samp_r);
	assign rx_framing_error_flag_now = rx_framing_error_flag_r | ~rx_bit;

	asu_noise_filter u_filter (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.line_in    (rxd_in),
		.mode_in    (ctl2_r[`ASU_C2_NF_HI:`ASU_C2_NF_LO]),
		.line_out   (rxd_clean)
	);

	// write-only control registers; control one shares its address with status, a read of control two returns zero
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctl1_r <= `ASU_C1_RESET; // R18
			ctl2_r <= `ASU_C2_RESET;
		end else if (wr_in) begin
			if (addr_in == `ASU_OFF_CTL1_STAT)
				ctl1_r <= wdata_in; // R17
			if (addr_in == `ASU_OFF_CTL2)
				ctl2_r <= wdata_in[2:0];
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rdata_r <= 8'h00;
		end else if (rd_stat) begin
			rdata_r <= {parity_error_flag_r, framing_error_flag_r, overrun_flag_r, receive_full_flag_r,
				transmit_done_flag_r, transmit_empty_flag_r, 2'b00}; // R16
		end else if (rd_rbuf) begin
			rdata_r <= rbuf_r; // R17
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// a status read arms the following buffer access on each side
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tx_armed_r <= 1'b0;
			rx_armed_r <= 1'b0;
		end else begin
			if (rd_stat)
				tx_armed_r <= 1'b1;
			else if (wr_tbuf)
				tx_armed_r <= 1'b0;
			if (rd_stat)
				rx_armed_r <= 1'b1;
			else if (rd_rbuf)
				rx_armed_r <= 1'b0;
		end
	end

	// sixteen-tick clock shared by both directions
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			div_cnt_r <= 9'h000;
			tick_r    <= 1'b0;
		end else if (ctl1_r[`ASU_C1_RATE_HI:`ASU_C1_RATE_LO]
			== `ASU_RATE_TIMER) begin
			div_cnt_r <= 9'h000;
			tick_r    <= timer_three_match_event_in; // R6 R13
		end else if (div_cnt_r >= divider_of(
			ctl1_r[`ASU_C1_RATE_HI:`ASU_C1_RATE_LO]) - 9'h001) begin
			div_cnt_r <= 9'h000; // R5 R13
			tick_r    <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 9'h001;
			tick_r    <= 1'b0;
		end
	end

	// transmit buffer and its flags; only armed writes start a frame
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tbuf_r    <= `ASU_BUF_RESET;
			pending_r <= 1'b0;
			transmit_empty_flag_r    <= 1'b1;
			transmit_done_flag_r    <= 1'b1;
		end else begin
			if (tx_load) begin
				pending_r <= 1'b0;
				transmit_empty_flag_r    <= 1'b1; // R15
				transmit_done_flag_r    <= 1'b0;
			end else if (!ctl1_r[`ASU_C1_TXE]
				&& tx_state_r == ASU_TX_IDLE) begin
				pending_r <= 1'b0; // R12
			end
			if (tx_end_r && !pending_r)
				transmit_done_flag_r <= 1'b1;
			if (wr_tbuf) begin
				tbuf_r <= wdata_in;
				if (tx_armed_r && ctl1_r[`ASU_C1_TXE]) begin
					pending_r <= 1'b1; // R20
					transmit_empty_flag_r    <= 1'b0;
				end
			end
		end
	end

	// transmit shifter; once started a frame runs out whatever enable says
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tx_state_r <= ASU_TX_IDLE;
			tx_sub_r   <= 4'h0;
			tx_idx_r   <= 3'h0;
			tx_stop_r  <= 1'b0;
			tx_shift_r <= 8'h00;
			txd_r      <= 1'b1;
			tx_int_r   <= 1'b0;
			tx_end_r   <= 1'b0;
		end else begin
			tx_int_r <= tx_load;
			tx_end_r <= 1'b0;
			case (tx_state_r)
				ASU_TX_IDLE: begin
					txd_r <= 1'b1; // R20
					if (tx_load) begin
						tx_shift_r <= tbuf_r;
						tx_state_r <= ASU_TX_START;
						tx_sub_r   <= 4'h0;
						txd_r      <= 1'b0; // R1
					end
				end
				default: begin
					if (tick_r) begin
						tx_sub_r <= tx_sub_r + 4'h1; // R25
					end
					if (tick_r && tx_sub_r == `ASU_TICK_LAST) begin
						case (tx_state_r)
							ASU_TX_START: begin
								tx_state_r <= ASU_TX_DATA;
								tx_idx_r   <= 3'h0;
								txd_r      <= tx_shift_r[0]; // R24
							end
							ASU_TX_DATA: begin
								tx_idx_r <= tx_idx_r + 3'h1;
								if (tx_idx_r == `ASU_DATA_LAST) begin
									tx_stop_r <= 1'b0;
									if (ctl1_r[`ASU_C1_PE]) begin
										tx_state_r <= ASU_TX_PARITY;
										// the buffer may already hold the next byte
										txd_r <= parity_of(tx_shift_r,
											ctl1_r[`ASU_C1_EVEN]); // R4
									end else begin
										tx_state_r <= ASU_TX_STOP;
										txd_r      <= 1'b1;
									end
								end else begin
									txd_r <= tx_shift_r[tx_idx_r + 3'h1];
								end
							end
							ASU_TX_PARITY: begin
								tx_state_r <= ASU_TX_STOP;
								txd_r      <= 1'b1; // R1
							end
							default: begin
								if (!tx_stop_r && ctl1_r[`ASU_C1_TRANSMIT_STOP_LENGTH]) begin
									tx_stop_r <= 1'b1; // R2
								end else begin
									tx_state_r <= ASU_TX_IDLE; // R11
									tx_end_r   <= 1'b1;
								end
							end
						endcase
					end
				end
			endcase
		end
	end

	// receive sequencer: sample at 7, 8, 9 and vote at the bit end
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rx_state_r    <= ASU_RX_IDLE;
			rx_sub_r      <= 4'h0;
			rx_idx_r      <= 3'h0;
			rx_stop_r     <= 1'b0;
			rx_samp_r     <= 3'h7;
			rx_shift_r    <= 8'h00;
			rx_par_r      <= 1'b0;
			rx_framing_error_flag_r     <= 1'b0;
			rx_done_r     <= 1'b0;
			rx_parity_error_flag_hit_r <= 1'b0;
			rx_framing_error_flag_hit_r <= 1'b0;
		end else begin
			rx_done_r <= 1'b0;
			if (tick_r) begin
				if (rx_state_r == ASU_RX_IDLE) begin
					// blocked while an overrun is still flagged
					if (!rxd_clean && ctl1_r[`ASU_C1_RXE] && !overrun_flag_r) begin
						rx_state_r <= ASU_RX_START; // R7 R22
						rx_sub_r   <= 4'h1;
						rx_framing_error_flag_r  <= 1'b0;
					end
				end else begin
					rx_sub_r <= rx_sub_r + 4'h1;
					if (rx_sub_r == `ASU_SAMPLE_A)
						rx_samp_r[0] <= rxd_clean; // R8
					if (rx_sub_r == `ASU_SAMPLE_B)
						rx_samp_r[1] <= rxd_clean;
					if (rx_sub_r == `ASU_SAMPLE_C)
						rx_samp_r[2] <= rxd_clean;
				end
				if (rx_state_r != ASU_RX_IDLE
					&& rx_sub_r == `ASU_TICK_LAST) begin
					case (rx_state_r)
						ASU_RX_START: begin
							rx_idx_r <= 3'h0;
							// a high vote means a glitch, not a start
							rx_state_r <= rx_bit ? ASU_RX_IDLE : ASU_RX_DATA;
						end
						ASU_RX_DATA: begin
							rx_shift_r <= {rx_bit, rx_shift_r[7:1]}; // R24
							rx_idx_r   <= rx_idx_r + 3'h1;
							rx_stop_r  <= 1'b0;
							if (rx_idx_r == `ASU_DATA_LAST)
								rx_state_r <= ctl1_r[`ASU_C1_PE]
									? ASU_RX_PARITY : ASU_RX_STOP;
						end
						ASU_RX_PARITY: begin
							rx_par_r   <= rx_bit;
							rx_state_r <= ASU_RX_STOP;
						end
						default: begin
							if (!rx_stop_r && ctl2_r[`ASU_C2_RECEIVE_STOP_LENGTH]) begin
								rx_stop_r <= 1'b1; // R3
								rx_framing_error_flag_r <= rx_framing_error_flag_now;
							end else begin
								rx_state_r    <= ASU_RX_IDLE; // R11
								rx_done_r     <= 1'b1;
								rx_framing_error_flag_hit_r <= rx_framing_error_flag_now; // R23
								rx_parity_error_flag_hit_r <= ctl1_r[`ASU_C1_PE]
									&& parity_of(rx_shift_r,
									ctl1_r[`ASU_C1_EVEN]) != rx_par_r;
							end
						end
					endcase
				end
			end
		end
	end

	// receive buffer and flags; a new event wins over a clear
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rbuf_r   <= `ASU_BUF_RESET;
			parity_error_flag_r   <= 1'b0;
			framing_error_flag_r   <= 1'b0;
			overrun_flag_r   <= 1'b0;
			receive_full_flag_r   <= 1'b0;
			rx_int_r <= 1'b0;
		end else begin
			rx_int_r <= 1'b0;
			if (rx_clear) begin
				parity_error_flag_r <= 1'b0; // R21
				framing_error_flag_r <= 1'b0;
				overrun_flag_r <= 1'b0;
				receive_full_flag_r <= 1'b0;
			end
			if (rx_done_r) begin
				if (receive_full_flag_r && !rx_clear) begin
					overrun_flag_r <= 1'b1; // R22
				end else begin
					rbuf_r   <= rx_shift_r;
					receive_full_flag_r   <= 1'b1;
					parity_error_flag_r   <= rx_parity_error_flag_hit_r; // R23
					framing_error_flag_r   <= rx_framing_error_flag_hit_r;
					rx_int_r <= 1'b1;
				end
			end
		end
	end

	assign rdata_out              = rdata_r;
	assign txd_out                = txd_r;
	assign transmit_interrupt_out = tx_int_r;
	assign receive_interrupt_out  = rx_int_r;

	a_tx_idle_high: assert property (@(posedge sys_clk_in) // R20
		disable iff (sys_rst_in)
		tx_state_r == ASU_TX_IDLE && !tx_load |=> txd_out)
		else $error("line not high while idle");

	a_tx_start_low: assert property (@(posedge sys_clk_in) // R1
		disable iff (sys_rst_in)
		tx_load |=> !txd_out && tx_state_r == ASU_TX_START)
		else $error("frame did not open with low start");

	a_tx_empty_set: assert property (@(posedge sys_clk_in) // R15
		disable iff (sys_rst_in)
		tx_load && !wr_tbuf |=> transmit_empty_flag_r && transmit_interrupt_out)
		else $error("empty flag not set with transmit event");

	a_tx_two_stops: assert property (@(posedge sys_clk_in) // R2
		disable iff (sys_rst_in)
		tx_state_r == ASU_TX_STOP && tick_r && tx_sub_r == 4'hF
		&& !tx_stop_r && ctl1_r[`ASU_C1_TRANSMIT_STOP_LENGTH]
		|=> tx_state_r == ASU_TX_STOP && txd_out)
		else $error("second stop bit missing");

	a_transmit_empty_flag_clear: assert property (@(posedge sys_clk_in) // R20
		disable iff (sys_rst_in)
		wr_tbuf && tx_armed_r && ctl1_r[`ASU_C1_TXE] |=> !transmit_empty_flag_r)
		else $error("armed write did not clear empty flag");

	a_rate_div13: assert property (@(posedge sys_clk_in) // R5
		disable iff (sys_rst_in)
		tick_r && ctl1_r[2:0] == 3'h0 && !wr_ctl1 ##1
		(!wr_ctl1 && !tick_r) [*8] ##1 (!wr_ctl1 && !tick_r) [*3]
		|-> ##1 !tick_r ##1 tick_r)
		else $error("fc/13 tick spacing wrong");

	a_overrun_keep: assert property (@(posedge sys_clk_in) // R22
		disable iff (sys_rst_in)
		rx_done_r && receive_full_flag_r && !rx_clear
		|=> overrun_flag_r && $stable(rbuf_r) && !receive_interrupt_out)
		else $error("overrun altered the buffer");

	a_framing_error_flag_set: assert property (@(posedge sys_clk_in) // R23
		disable iff (sys_rst_in)
		rx_done_r && rx_framing_error_flag_hit_r && !(receive_full_flag_r && !rx_clear)
		|=> framing_error_flag_r && receive_full_flag_r)
		else $error("framing error not flagged");

	a_rx_clear: assert property (@(posedge sys_clk_in) // R21
		disable iff (sys_rst_in)
		rx_clear && !rx_done_r |=> !receive_full_flag_r && !overrun_flag_r && !parity_error_flag_r)
		else $error("receive flags not cleared");

	a_rx_blocked: assert property (@(posedge sys_clk_in) // R22
		disable iff (sys_rst_in)
		rx_state_r == ASU_RX_IDLE && overrun_flag_r |=> rx_state_r == ASU_RX_IDLE)
		else $error("reception ran during overrun");

	c_tx_frame: cover property (@(posedge sys_clk_in) disable iff
		(sys_rst_in) tx_end_r);
	c_rx_load: cover property (@(posedge sys_clk_in) disable iff
		(sys_rst_in) receive_interrupt_out);
	c_overrun: cover property (@(posedge sys_clk_in) disable iff
		(sys_rst_in) rx_done_r && receive_full_flag_r);
	c_parity_err: cover property (@(posedge sys_clk_in) disable iff
		(sys_rst_in) rx_done_r && rx_parity_error_flag_hit_r);

endmodule
